// ===== verilog/uart_register_interface.sv
// Register block and character engines of a simple asynchronous serial transceiver.
// Assumes an APB master on clk, DMA channel flags on clk, and an asynchronous rx pin.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module uart_register_interface
  import uart_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire apb_req_t apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dma_flags_t dmaFlags,
  input wire logic wakeEnable,
  input wire logic serialRxLine,
  output logic serialTxLine,
  output logic clockRequest
);
  if (DIV_W < 2 || DIV_W > 16) begin : g_bad_div
    $error("DIV_W must lie between 2 and 16");
  end

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Parity bit for a character under a parity setting.
  function automatic logic parityOf(input logic [7:0] d, input parity_t s);
    parityOf = (s == PAR_EVEN) ? ^d : (s == PAR_ODD) ? ~^d : (s == PAR_MARK);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  logic [15:0] mode_q;
  logic [DIV_W-1:0] baud_q;
  logic [31:0] compare_q;
  logic [15:0] imr_q;
  logic protectEn_q;
  logic rxSync1_q, rxSync2_q, rxPrev_q;
  logic rx_enable_cmd_q, rxDisPend_q, tx_enable_cmd_q, txDisPend_q;
  rx_state_t rxState_q;
  logic [3:0] rxTick_q;
  logic [2:0] rxBit_q;
  logic [7:0] rxData_q, rhr_q;
  logic rxParErr_q;
  logic rxReady_q, overrun_q, framing_q, parErr_q, cmpFlag_q, cmpArmed_q;
  logic thrFull_q;
  logic [7:0] thr_q;
  logic [10:0] txShift_q;
  logic [3:0] txBitsLeft_q, txTick_q;
  logic tick16, lineF;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire answer = apbReq.psel & apbReq.penable & ~pready;
  wire access = apbReq.psel & apbReq.penable & pready;
  wire wr = access & apbReq.pwrite;
  wire [31:0] wd = apbReq.pwdata;
  wire [11:0] ad = apbReq.paddr;
  wire wrCtl = wr && ad == OFS_CONTROL;
  wire wrMode = wr && ad == OFS_MODE && !protectEn_q;
  wire wrIer = wr && ad == OFS_IRQ_EN;
  wire wrIdr = wr && ad == OFS_IRQ_DIS;
  wire wrThr = wr && ad == OFS_TX_HOLD;
  wire wrBaud = wr && ad == OFS_BAUD && !protectEn_q;
  wire wrCmp = wr && ad == OFS_COMPARE && !protectEn_q;
  wire wrProt = wr && ad == OFS_PROTECT;
  wire keyOk = wd[31:WP_KEY_LSB] == PROTECT_KEY;
  wire rdRhr = answer && !apbReq.pwrite && ad == OFS_RX_HOLD;
  wire mapped = ad == OFS_CONTROL || ad == OFS_MODE || ad == OFS_IRQ_EN ||
                ad == OFS_IRQ_DIS || ad == OFS_IRQ_MASK || ad == OFS_STATUS ||
                ad == OFS_RX_HOLD || ad == OFS_TX_HOLD || ad == OFS_BAUD ||
                ad == OFS_COMPARE || ad == OFS_PROTECT;

  // Command bits of a control write.
  wire cRxRst = wrCtl & wd[CR_RX_RESET];
  wire cTxRst = wrCtl & wd[CR_TX_RESET];
  wire cRxEn = wrCtl & wd[CR_RX_EN] & ~wd[CR_RX_DIS];
  wire cRxDis = wrCtl & wd[CR_RX_DIS];
  wire cTxEn = wrCtl & wd[CR_TX_EN] & ~wd[CR_TX_DIS];
  wire cTxDis = wrCtl & wd[CR_TX_DIS];
  wire cClear = wrCtl & wd[CR_CLEAR_STATUS];
  wire cCancel = wrCtl & wd[CR_REQ_CANCEL];

  // Mode and compare fields.
  wire filterEn = mode_q[MR_FILTER];
  wire parity_t parSel = parity_t'(mode_q[MR_PAR_LSB +: 3]);
  wire channel_loop_select_t channel_loop_select = channel_loop_select_t'(mode_q[MR_CHANNEL_LOOP_SELECT_LSB +: 2]);
  wire [7:0] compare_first_value = compare_q[CMP_COMPARE_FIRST_VALUE_LSB +: 8];
  wire [7:0] compare_second_value = compare_q[CMP_COMPARE_SECOND_VALUE_LSB +: 8];
  wire cmpGate = compare_q[CMP_GATE];
  wire compare_with_parity = compare_q[CMP_PAR];

  // ****************************************************************
  // Status word and read multiplexer
  // ****************************************************************
  wire txFree = tx_enable_cmd_q & ~thrFull_q;
  wire txIdle = txFree & (txBitsLeft_q == 4'h0);
  logic [15:0] status;
  always_comb begin
    status = 16'h0000;
    status[SR_RX_READY] = rxReady_q;
    status[SR_TX_FREE] = txFree;
    status[SR_RX_DMA_DONE] = dmaFlags.rxEnd;
    status[SR_TX_DMA_DONE] = dmaFlags.txEnd;
    status[SR_OVERRUN] = overrun_q;
    status[SR_FRAMING] = framing_q;
    status[SR_PARITY] = parErr_q;
    status[SR_TX_IDLE] = txIdle;
    status[SR_TX_DMA_EMPTY] = dmaFlags.txBufEmpty;
    status[SR_RX_DMA_FULL] = dmaFlags.rxBufFull;
    status[SR_COMPARE] = cmpFlag_q;
  end
  wire [31:0] rdData =
    (ad == OFS_MODE) ? {16'h0000, mode_q} :
    (ad == OFS_IRQ_MASK) ? {16'h0000, imr_q} :
    (ad == OFS_STATUS) ? {16'h0000, status} :
    (ad == OFS_RX_HOLD) ? {24'h000000, rhr_q} :
    (ad == OFS_BAUD) ? {{(32 - DIV_W){1'b0}}, baud_q} :
    (ad == OFS_COMPARE) ? compare_q :
    (ad == OFS_PROTECT) ? {31'h00000000, protectEn_q} : 32'h00000000;

  // One wait state: the answer is prepared in the first access cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= answer;
      pslverr <= answer & ~mapped;
      if (answer) begin
        prdata <= apbReq.pwrite ? 32'h00000000 : rdData;
      end
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= MODE_RESET;
      baud_q <= BAUD_RESET[DIV_W-1:0];
      compare_q <= COMPARE_RESET;
      imr_q <= MASK_RESET;
      protectEn_q <= 1'b0;
    end else begin
      if (wrMode) mode_q <= wd[15:0] & 16'hce10;
      if (wrBaud) baud_q <= wd[DIV_W-1:0];
      if (wrCmp) compare_q <= wd & 32'h00ff50ff;
      if (wrIer) imr_q <= imr_q | (wd[15:0] & SR_USED_MASK);
      else if (wrIdr) imr_q <= imr_q & ~wd[15:0];
      if (wrProt && keyOk) protectEn_q <= wd[0];
    end
  end

  // ****************************************************************
  // Receive line: synchroniser, divider and filter
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxSync1_q <= 1'b1;
      rxSync2_q <= 1'b1;
    end else begin
      rxSync1_q <= serialRxLine;
      rxSync2_q <= rxSync1_q;
    end
  end

  uart_baud_filter #(.DIV_W(DIV_W)) u_baud (
    .clk(clk),
    .nrst(nrst),
    .divisor(baud_q),
    .filterEn(filterEn),
    .lineIn(rxSync2_q),
    .tick16(tick16),
    .lineOut(lineF)
  );

  // ****************************************************************
  // Receiver
  // ****************************************************************
  wire txBit = (txBitsLeft_q != 4'h0) ? txShift_q[0] : 1'b1;
  wire rxIn = (channel_loop_select == CH_LOCAL) ? txBit : lineF;
  wire rxRun = rx_enable_cmd_q && channel_loop_select != CH_REMOTE;
  wire rxLast = tick16 && rxTick_q == TICKS_LAST;
  wire rxDone = rxState_q == RX_STOP && rxLast;
  wire inRange = rxData_q >= compare_first_value && rxData_q <= compare_second_value;
  wire cmpHit = (compare_first_value < compare_second_value) ? inRange : (rxData_q == compare_first_value || rxData_q == compare_second_value);
  wire match = cmpHit && !(compare_with_parity && rxParErr_q);
  wire gateOpen = !cmpGate || cmpArmed_q || wakeEnable;
  wire load = rxDone && (gateOpen || match);

  // Frame walk at 16x: start checked mid-bit, then one sample per bit.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxState_q <= RX_IDLE;
      rxTick_q <= 4'h0;
      rxBit_q <= 3'h0;
      rxData_q <= 8'h00;
      rxParErr_q <= 1'b0;
    end else if (cRxRst) begin
      rxState_q <= RX_IDLE;
    end else if (tick16) begin
      rxTick_q <= rxTick_q + 4'h1;
      unique case (rxState_q)
        RX_IDLE: begin
          rxTick_q <= 4'h0;
          if (rxRun && !rxDisPend_q && !rxIn) rxState_q <= RX_START;
        end
        RX_START: if (rxTick_q == TICKS_HALF) begin
          rxTick_q <= 4'h0;
          rxBit_q <= 3'h0;
          rxParErr_q <= 1'b0;
          rxState_q <= rxIn ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rxLast) begin
          rxData_q <= {rxIn, rxData_q[7:1]};
          rxBit_q <= rxBit_q + 3'h1;
          if (rxBit_q == 3'h7) rxState_q <= (parSel == PAR_NONE) ? RX_STOP : RX_PARITY;
        end
        RX_PARITY: if (rxLast) begin
          rxParErr_q <= rxIn != parityOf(rxData_q, parSel);
          rxState_q <= RX_STOP;
        end
        RX_STOP: if (rxLast) rxState_q <= RX_IDLE;
        default: rxState_q <= RX_IDLE;
      endcase
    end
  end

  // Receiver enable, with a disable that waits for the frame to end.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_enable_cmd_q <= 1'b0;
      rxDisPend_q <= 1'b0;
    end else if (cRxRst) begin
      rx_enable_cmd_q <= 1'b0;
      rxDisPend_q <= 1'b0;
    end else if (cRxDis || rxDisPend_q) begin
      rxDisPend_q <= rxState_q != RX_IDLE;
      rx_enable_cmd_q <= rx_enable_cmd_q && rxState_q != RX_IDLE;
    end else if (cRxEn) begin
      rx_enable_cmd_q <= 1'b1;
    end
  end

  // Holding register, sticky flags and compare trigger; a set beats a clear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rhr_q <= 8'h00;
      rxReady_q <= 1'b0;
      overrun_q <= 1'b0;
      framing_q <= 1'b0;
      parErr_q <= 1'b0;
      cmpFlag_q <= 1'b0;
      cmpArmed_q <= 1'b0;
    end else begin
      if (load) rhr_q <= rxData_q;
      rxReady_q <= load || (rxReady_q && !rdRhr && rx_enable_cmd_q && !cRxRst);
      overrun_q <= (load && rxReady_q && !rdRhr) || (overrun_q && !cClear);
      framing_q <= (rxDone && !rxIn) || (framing_q && !cClear);
      parErr_q <= (rxDone && rxParErr_q) || (parErr_q && !cClear);
      cmpFlag_q <= (load && match) || (cmpFlag_q && !cClear);
      if (rxDone && match && cmpGate) cmpArmed_q <= 1'b1;
      else if (cCancel && !wakeEnable) cmpArmed_q <= 1'b0;
    end
  end

  // Clock request: raised by a falling receive line, kept only on a match.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxPrev_q <= 1'b1;
      clockRequest <= 1'b0;
    end else begin
      rxPrev_q <= lineF;
      if (!wakeEnable || (cCancel && wakeEnable)) clockRequest <= 1'b0;
      else if (rxPrev_q && !lineF) clockRequest <= 1'b1;
      else if (rxDone && !match) clockRequest <= 1'b0;
    end
  end

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  wire txLoad = tx_enable_cmd_q && thrFull_q && txBitsLeft_q == 4'h0;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      thrFull_q <= 1'b0;
      thr_q <= 8'h00;
      txShift_q <= 11'h7ff;
      txBitsLeft_q <= 4'h0;
      txTick_q <= 4'h0;
    end else if (cTxRst) begin
      thrFull_q <= 1'b0;
      txBitsLeft_q <= 4'h0;
    end else if (txLoad) begin
      thrFull_q <= wrThr;
      if (wrThr) thr_q <= wd[7:0];
      txTick_q <= 4'h0;
      txShift_q <= (parSel == PAR_NONE) ? {2'b11, thr_q, 1'b0} :
                   {1'b1, parityOf(thr_q, parSel), thr_q, 1'b0};
      txBitsLeft_q <= (parSel == PAR_NONE) ? FRAME_BITS_NOPAR : FRAME_BITS_PAR;
    end else begin
      if (wrThr) begin
        thrFull_q <= 1'b1;
        thr_q <= wd[7:0];
      end
      if (tick16 && txBitsLeft_q != 4'h0) begin
        txTick_q <= txTick_q + 4'h1;
        if (txTick_q == TICKS_LAST) begin
          txShift_q <= {1'b1, txShift_q[10:1]};
          txBitsLeft_q <= txBitsLeft_q - 4'h1;
        end
      end
    end
  end

  // Transmitter enable; a disable drains shifter and holding register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_enable_cmd_q <= 1'b0;
      txDisPend_q <= 1'b0;
    end else if (cTxRst) begin
      tx_enable_cmd_q <= 1'b0;
      txDisPend_q <= 1'b0;
    end else if (cTxDis || txDisPend_q) begin
      txDisPend_q <= thrFull_q || txBitsLeft_q != 4'h0;
      tx_enable_cmd_q <= tx_enable_cmd_q && (thrFull_q || txBitsLeft_q != 4'h0);
    end else if (cTxEn) begin
      tx_enable_cmd_q <= 1'b1;
    end
  end

  // Output pin per channel mode.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      serialTxLine <= 1'b1;
    end else begin
      unique case (channel_loop_select)
        CH_NORMAL: serialTxLine <= txBit;
        CH_LOCAL: serialTxLine <= 1'b1;
        CH_ECHO, CH_REMOTE: serialTxLine <= rxSync2_q;
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_ctlWrite;
    wr ##0 (ad == OFS_CONTROL);
  endsequence
  property p_rxResetAborts;
    s_ctlWrite ##0 wd[CR_RX_RESET] |=> !rx_enable_cmd_q && rxState_q == RX_IDLE && !rxReady_q;
  endproperty
  a_rxResetAborts: assert property (p_rxResetAborts) else $error("rx reset failed");
  property p_txResetAborts;
    s_ctlWrite ##0 wd[CR_TX_RESET] |=> !tx_enable_cmd_q && txBitsLeft_q == 4'h0 && !thrFull_q;
  endproperty
  a_txResetAborts: assert property (p_txResetAborts) else $error("tx reset failed");
  property p_rxDisWins;
    s_ctlWrite ##0 (wd[CR_RX_EN] && wd[CR_RX_DIS] && rxState_q == RX_IDLE) |=> !rx_enable_cmd_q;
  endproperty
  a_rxDisWins: assert property (p_rxDisWins) else $error("rx disable lost");
  property p_clearStatus;
    cClear && !rxDone |=> !overrun_q && !framing_q && !parErr_q && !cmpFlag_q;
  endproperty
  a_clearStatus: assert property (p_clearStatus) else $error("status not cleared");
  property p_maskSet;
    wrIer |=> (imr_q & $past(wd[15:0]) & SR_USED_MASK) == ($past(wd[15:0]) & SR_USED_MASK);
  endproperty
  a_maskSet: assert property (p_maskSet) else $error("mask not set");
  property p_maskClear;
    wrIdr |=> (imr_q & $past(wd[15:0])) == 16'h0000;
  endproperty
  a_maskClear: assert property (p_maskClear) else $error("mask not cleared");
  property p_txReadyOff;
    !tx_enable_cmd_q |-> !status[SR_TX_FREE] && !status[SR_TX_IDLE];
  endproperty
  a_txReadyOff: assert property (p_txReadyOff) else $error("tx flags while off");
  property p_txDrain;
    cTxDis && !cTxRst && thrFull_q && tx_enable_cmd_q |=> tx_enable_cmd_q [*2];
  endproperty
  a_txDrain: assert property (p_txDrain) else $error("tx stopped early");
  property p_keyGuard;
    wrProt && !keyOk |=> $stable(protectEn_q);
  endproperty
  a_keyGuard: assert property (p_keyGuard) else $error("bad key accepted");
  property p_apbAnswer;
    answer |=> pready ##1 !pready;
  endproperty
  a_apbAnswer: assert property (p_apbAnswer) else $error("apb answer timing");
endmodule

// ===== verilog/uart_pkg.sv
// Constants, types and register map of the serial transceiver register block.
// Assumes a 100 MHz peripheral clock and a 32-bit APB master.
package uart_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] OFS_CONTROL = 12'h000;
  localparam logic [11:0] OFS_MODE = 12'h004;
  localparam logic [11:0] OFS_IRQ_EN = 12'h008;
  localparam logic [11:0] OFS_IRQ_DIS = 12'h00c;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_RX_HOLD = 12'h018;
  localparam logic [11:0] OFS_TX_HOLD = 12'h01c;
  localparam logic [11:0] OFS_BAUD = 12'h020;
  localparam logic [11:0] OFS_COMPARE = 12'h024;
  localparam logic [11:0] OFS_PROTECT = 12'h0e4;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CR_RX_RESET = 2;
  localparam int CR_TX_RESET = 3;
  localparam int CR_RX_EN = 4;
  localparam int CR_RX_DIS = 5;
  localparam int CR_TX_EN = 6;
  localparam int CR_TX_DIS = 7;
  localparam int CR_CLEAR_STATUS = 8;
  localparam int CR_REQ_CANCEL = 12;
  localparam int MR_FILTER = 4;
  localparam int MR_PAR_LSB = 9;
  localparam int MR_CHANNEL_LOOP_SELECT_LSB = 14;
  localparam int SR_RX_READY = 0;
  localparam int SR_TX_FREE = 1;
  localparam int SR_RX_DMA_DONE = 3;
  localparam int SR_TX_DMA_DONE = 4;
  localparam int SR_OVERRUN = 5;
  localparam int SR_FRAMING = 6;
  localparam int SR_PARITY = 7;
  localparam int SR_TX_IDLE = 9;
  localparam int SR_TX_DMA_EMPTY = 11;
  localparam int SR_RX_DMA_FULL = 12;
  localparam int SR_COMPARE = 15;
  localparam logic [15:0] SR_USED_MASK = 16'h9afb;
  localparam int CMP_COMPARE_FIRST_VALUE_LSB = 0;
  localparam int CMP_GATE = 12;
  localparam int CMP_PAR = 14;
  localparam int CMP_COMPARE_SECOND_VALUE_LSB = 16;
  localparam int WP_KEY_LSB = 8;
  localparam logic [23:0] PROTECT_KEY = 24'h554152;

  // ****************************************************************
  // Reset values and bit timing
  // ****************************************************************
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  localparam logic [31:0] COMPARE_RESET = 32'h00000000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [3:0] TICKS_HALF = 4'h7;
  localparam logic [3:0] TICKS_LAST = 4'hf;
  localparam logic [3:0] FRAME_BITS_PAR = 4'hb;
  localparam logic [3:0] FRAME_BITS_NOPAR = 4'ha;

  typedef enum logic [2:0] {
    PAR_EVEN = 3'h0, PAR_ODD = 3'h1, PAR_SPACE = 3'h2, PAR_MARK = 3'h3, PAR_NONE = 3'h4
  } parity_t;
  typedef enum logic [1:0] {
    CH_NORMAL = 2'h0, CH_ECHO = 2'h1, CH_LOCAL = 2'h2, CH_REMOTE = 2'h3
  } channel_loop_select_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2, RX_PARITY = 3'h3, RX_STOP = 3'h4
  } rx_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic rxEnd;
    logic txEnd;
    logic txBufEmpty;
    logic rxBufFull;
  } dma_flags_t;

endpackage

// ===== verilog/uart_baud_filter.sv
// Baud divider giving a 16x oversampling enable, plus the receive line filter.
// Assumes lineIn is already synchronised to clk.
`timescale 1ns/1ps
module uart_baud_filter #(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [DIV_W-1:0] divisor,
  input wire logic filterEn,
  input wire logic lineIn,
  output logic tick16,
  output logic lineOut
);
  logic [DIV_W-1:0] cnt_q;
  logic [2:0] hist_q;
  wire divRun = (divisor != '0);
  wire divWrap = divRun && (cnt_q >= divisor - 1'b1);
  wire vote = (hist_q[0] & hist_q[1]) | (hist_q[1] & hist_q[2]) | (hist_q[0] & hist_q[2]);

  // ****************************************************************
  // Divider: one enable pulse every divisor cycles, none at zero.
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      tick16 <= 1'b0;
    end else begin
      cnt_q <= (divWrap || !divRun) ? '0 : cnt_q + 1'b1;
      tick16 <= divWrap;
    end
  end

  // Three samples at the oversampling rate, two of three win.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hist_q <= 3'h7;
      lineOut <= 1'b1;
    end else begin
      if (divWrap) begin
        hist_q <= {hist_q[1:0], lineIn};
      end
      lineOut <= filterEn ? vote : lineIn;
    end
  end
endmodule

// ===== verification/uart_remote_peer.sv
// Remote serial device that sends one frame on the receive line per go pulse.
// Assumes the bench clock and a bit of BIT cycles (baud divisor 1 gives 16).
`timescale 1ns/1ps
module uart_remote_peer #(
  parameter int BIT = 16
) (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] data,
  input wire logic badPar,
  output logic line
);
  logic [10:0] frame;
  initial line = 1'b1;
  // Start, eight data bits LSB first, even parity (flipped on request), stop.
  always @(posedge clk) begin
    if (go) begin
      frame = {1'b1, ^data ^ badPar, data, 1'b0};
      for (int i = 0; i < 11; i++) begin
        line <= frame[i];
        repeat (BIT) @(posedge clk);
      end
      line <= 1'b1; // The idle line is high.
    end
  end
endmodule

// ===== verification/tb.sv
// Self-checking bench of the register block: APB master, row table, serial tests.
// Assumes the design package and a remote peer model on the receive line.
`timescale 1ns/1ps
module tb;
  import uart_pkg::*;
  typedef struct packed {
    logic [11:0] wa;
    logic [31:0] wd;
    logic [11:0] ra;
    logic [31:0] e;
  } row_t;
  logic clk = 1'b0, nrst = 1'b0, wakeEnable = 1'b0, go = 1'b0, badPar = 1'b0;
  logic pready, pslverr, rxLine, txLine, clockRequest, errq;
  logic [7:0] pData = 8'h00;
  logic [31:0] prdata, rdq;
  apb_req_t apbReq = '0;
  dma_flags_t dmaFlags = '0;
  int err_count = 0, n_tests = 0;
  row_t rows[12] = '{
    '{OFS_CONTROL, 32'h0, OFS_STATUS, 32'h0},
    '{OFS_IRQ_EN, 32'h9afb, OFS_IRQ_MASK, 32'h9afb},
    '{OFS_IRQ_DIS, 32'h3, OFS_IRQ_MASK, 32'h9af8},
    '{OFS_MODE, 32'hffffffff, OFS_MODE, 32'hce10},
    '{OFS_COMPARE, 32'hffffffff, OFS_COMPARE, 32'hff50ff},
    '{OFS_PROTECT, 32'h55415201, OFS_PROTECT, 32'h1},
    '{OFS_MODE, 32'h0, OFS_MODE, 32'hce10},
    '{OFS_PROTECT, 32'h0, OFS_PROTECT, 32'h1},
    '{OFS_PROTECT, 32'h55415200, OFS_PROTECT, 32'h0},
    '{OFS_MODE, 32'h0, OFS_MODE, 32'h0},
    '{OFS_COMPARE, 32'hff0000, OFS_COMPARE, 32'hff0000},
    '{OFS_BAUD, 32'h1, OFS_BAUD, 32'h1}
  };

  // The clock toggles every half period of 5 ns.
  always #5 clk = ~clk;

  uart_register_interface uart_register_interface_inst (.clk(clk), .nrst(nrst),
    .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dmaFlags(dmaFlags), .wakeEnable(wakeEnable), .serialRxLine(rxLine),
    .serialTxLine(txLine), .clockRequest(clockRequest));
  uart_remote_peer uart_remote_peer_inst (.clk(clk), .go(go), .data(pData),
    .badPar(badPar), .line(rxLine));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      print_verdict();
    end
    rdq = prdata;
    errq = pslverr;
    apbReq <= '0;
  endtask

  // Polls the status word until the given bit is set, within a bound.
  task automatic waitSr(input int b);
    int n;
    n = 0;
    do begin
      xfer(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rdq[b] !== 1'b1 && n < 80);
    if (n >= 80) begin
      err_count++;
      print_verdict();
    end
    repeat (20) @(posedge clk);
  endtask

  task automatic send(input logic [7:0] v, input logic bad);
    pData <= v;
    badPar <= bad;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask

  // Samples one frame of the transmit pin at mid-bit: start, data, even parity, stop.
  task automatic txFrame(input logic [7:0] v);
    logic [10:0] f;
    int n;
    n = 0;
    while (txLine !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      err_count++;
      print_verdict();
    end
    repeat (8) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      f[i] = txLine;
      if (i < 10) repeat (16) @(posedge clk);
    end
    chk({21'h0, f}, {21'h0, 1'b1, ^v, v, 1'b0});
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].wa, rows[i].wd);
      xfer(1'b0, rows[i].ra, 32'h0);
      chk(rdq, rows[i].e);
    end
    xfer(1'b0, 12'h030, 32'h0);
    chk({31'h0, errq}, 32'h1);
    $display("test registers done");
    xfer(1'b1, OFS_CONTROL, 32'h30);
    xfer(1'b1, OFS_CONTROL, 32'h10);
    send(8'h5a, 1'b0);
    waitSr(SR_RX_READY);
    chk(rdq, 32'h8001);
    xfer(1'b1, OFS_COMPARE, 32'ha500c0);
    xfer(1'b1, OFS_CONTROL, 32'h100);
    send(8'ha5, 1'b1);
    waitSr(SR_PARITY);
    chk(rdq, 32'h80a1);
    xfer(1'b0, OFS_RX_HOLD, 32'h0);
    chk(rdq, 32'ha5);
    xfer(1'b1, OFS_CONTROL, 32'h100);
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(rdq, 32'h0);
    $display("test receive done");
    xfer(1'b1, OFS_CONTROL, 32'h40);
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(rdq, 32'h202);
    xfer(1'b1, OFS_TX_HOLD, 32'h33);
    // A second character waits in the holding register when the disable arrives.
    fork
      txFrame(8'h33);
      begin
        xfer(1'b1, OFS_TX_HOLD, 32'hc3);
        xfer(1'b1, OFS_CONTROL, 32'h80);
      end
    join
    txFrame(8'hc3);
    repeat (20) @(posedge clk);
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(rdq, 32'h0);
    // Local loopback: the character comes back inside while the pin stays high.
    xfer(1'b1, OFS_MODE, 32'h8000);
    xfer(1'b1, OFS_CONTROL, 32'h50);
    xfer(1'b1, OFS_TX_HOLD, 32'h6c);
    repeat (10) @(posedge clk);
    chk({31'h0, txLine}, 32'h1);
    waitSr(SR_RX_READY);
    xfer(1'b0, OFS_RX_HOLD, 32'h0);
    chk(rdq, 32'h6c);
    xfer(1'b1, OFS_MODE, 32'h0);
    // Wake-up: a matching character keeps the clock request until cancelled.
    wakeEnable <= 1'b1;
    send(8'hc0, 1'b0);
    repeat (200) @(posedge clk);
    chk({31'h0, clockRequest}, 32'h1);
    xfer(1'b1, OFS_CONTROL, 32'h1100);
    @(posedge clk);
    chk({31'h0, clockRequest}, 32'h0);
    wakeEnable <= 1'b0;
    xfer(1'b1, OFS_TX_HOLD, 32'h33);
    for (int n = 0; n < 40 && txLine !== 1'b0; n++) @(posedge clk);
    chk({31'h0, txLine}, 32'h0);
    xfer(1'b1, OFS_CONTROL, 32'hc);
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk({rdq[31:1], txLine}, 32'h1);
    dmaFlags <= '1;
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(rdq, 32'h1818);
    $display("test transmit done");
    print_verdict();
  end
endmodule
